// >>> core/ufp_core.sv
`default_nettype none
module ufp_core
  import ufp_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic [AW-1:0] address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [7:0]    writedata,
  output logic      [7:0]    readdata,
  output logic               waitrequest,
  input  wire ufp_link_ev_t  ev,
  output ufp_link_cmd_t      cmd,
  output logic               irq,
  output logic               link_inhibit,
  output logic               resume_drive,
  output logic               suspend_state_flag,
  output logic      [6:0]    function_addr_reg
);
  typedef struct packed {
    logic          wreq;
    logic [7:0]    rdata;
    logic [1:0]    clrin;
    logic [3:0]    clrcm;
    logic [6:0]    fn_addr;
    logic [3:0]    index;
    logic          iso;
    logic          inh;
    logic          resume;
    logic          susp;
    logic          susdet;
    logic [1:0]    inen;
    logic [3:0]    cmen;
    logic [10:0]   frame;
    logic          brst_q;
    logic          iso_pend;
    ufp_link_cmd_t cmd;
    logic          irq;
  } ufp_st_t;

  ufp_st_t          s_r;
  ufp_st_t          s_nxt;
  logic             swrst_r;
  logic             swrst_nxt;
  logic             arst;
  logic [IN_W-1:0]  in_flags;
  logic [CM_W-1:0]  cm_flags;
  logic [IN_W-1:0]  in_set;
  logic [CM_W-1:0]  cm_set;
  logic [IN_W-1:0]  in_clr;
  logic [CM_W-1:0]  cm_clr;
  logic             rd_acc;
  logic             wr_acc;
  logic             live;
  logic             brst_rise;
  logic [7:0]       rd_mux;

  assign arst = rst | swrst_r;

  // ==========================================================
  // Flag banks
  ufp_flag_bank #(.W(IN_W)) u_in_flags (
    .clock (clock),
    .rst   (arst),
    .set   (in_set),
    .clr   (in_clr),
    .flags (in_flags)
  );

  ufp_flag_bank #(.W(CM_W)) u_cm_flags (
    .clock (clock),
    .rst   (arst),
    .set   (cm_set),
    .clr   (cm_clr),
    .flags (cm_flags)
  );

  // ==========================================================
  // Access and event decode
  assign rd_acc    = read & ~s_r.wreq;
  assign wr_acc    = write & ~s_r.wreq;
  assign live      = ~s_r.inh;
  assign brst_rise = live & ev.bus_reset & ~s_r.brst_q;

  always_comb begin
    in_set         = '0;
    cm_set         = '0;
    in_set[IN_EP1] = live & ev.ep1_in & s_r.inen[IN_EP1];
    in_set[IN_CTL] = live & ev.ctl_ep & s_r.inen[IN_CTL];
    cm_set[CM_SOF] = live & ev.sof & s_r.cmen[CM_SOF];
    cm_set[CM_RST] = brst_rise;
    cm_set[CM_RSU] = live & ev.resume & s_r.susp & s_r.cmen[CM_RSU];
    cm_set[CM_SUS] = live & ev.suspend & s_r.susdet & s_r.cmen[CM_SUS];
  end

  // A read clears only the bits it returned; a bus reset sets the bus-reset flag and clears every flag not set in the same cycle
  assign in_clr = (rd_acc ? s_r.clrin : '0) | {IN_W{brst_rise}};
  assign cm_clr = (rd_acc ? s_r.clrcm : '0) | {CM_W{brst_rise}};

  always_comb begin
    rd_mux = 8'h00;
    case (address)
      IDX_FNADDR: rd_mux = {1'b0, s_r.fn_addr};
      IDX_CTRL:  rd_mux = {s_r.iso, 2'b00, s_r.inh, ev.bus_reset,
                          s_r.resume, s_r.susp, s_r.susdet};
      IDX_INFLG: rd_mux = {6'h00, in_flags};
      IDX_CMFLG: rd_mux = {4'h0, cm_flags};
      IDX_INEN:  rd_mux = {6'h00, s_r.inen};
      IDX_CMEN:  rd_mux = {4'h0, s_r.cmen};
      IDX_FRML:  rd_mux = s_r.frame[7:0];
      IDX_FRMH:  rd_mux = {5'h00, s_r.frame[10:8]};
      IDX_INDEX: rd_mux = {4'h0, s_r.index};
      default:   rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt        = s_r;
    s_nxt.wreq   = ~((read | write) & s_r.wreq);
    s_nxt.brst_q = ev.bus_reset;
    s_nxt.cmd    = '0;
    s_nxt.cmd.iso_ready = s_r.cmd.iso_ready;
    if (read & s_r.wreq) begin
      s_nxt.rdata = rd_mux;
      s_nxt.clrin = (address == IDX_INFLG) ? in_flags : '0;
      s_nxt.clrcm = (address == IDX_CMFLG) ? cm_flags : '0;
    end
    // Flag registers have no write path
    if (wr_acc) begin
      case (address)
        IDX_FNADDR: s_nxt.fn_addr = writedata[6:0];
        IDX_INDEX: s_nxt.index = writedata[3:0];
        IDX_INEN:  s_nxt.inen  = writedata[1:0];
        IDX_CMEN:  s_nxt.cmen  = writedata[3:0];
        IDX_CTRL: begin
          s_nxt.iso    = writedata[CTRL_ISO];
          s_nxt.resume = writedata[CTRL_RES];
          s_nxt.susdet = writedata[CTRL_SUSDET];
          if (!writedata[CTRL_INH]) begin
            s_nxt.inh = 1'b0;
          end
          if (s_r.resume & ~writedata[CTRL_RES]) begin
            s_nxt.susp = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Suspend tracking and frame number capture
    if (live & ev.suspend & s_r.susdet) begin
      s_nxt.susp = 1'b1;
    end
    if (live & ev.resume) begin
      s_nxt.susp = 1'b0;
    end
    if (live & ev.sof) begin
      s_nxt.frame = ev.frame;
    end
    // ISO IN release
    if (live & ev.iso_load) begin
      if (s_r.iso) begin
        s_nxt.iso_pend = 1'b1;
      end else begin
        s_nxt.cmd.iso_ready = 1'b1;
      end
    end
    if (live & ev.sof & s_r.iso_pend) begin
      s_nxt.iso_pend      = 1'b0;
      s_nxt.cmd.iso_ready = 1'b1;
    end
    if (live & ev.iso_token) begin
      if (s_r.cmd.iso_ready) begin
        s_nxt.cmd.iso_ready = 1'b0;
      end else if (s_r.iso_pend) begin
        s_nxt.cmd.iso_zlp = 1'b1;
      end
    end
    // Bus reset handling
    if (brst_rise) begin
      s_nxt.fn_addr        = FNADDR_RST;
      s_nxt.index          = INDEX_RST;
      s_nxt.inen           = '1;
      s_nxt.cmen           = s_r.cmen | CMEN_BUSRST;
      s_nxt.susp           = 1'b0;
      s_nxt.iso_pend       = 1'b0;
      s_nxt.cmd.iso_ready  = 1'b0;
      s_nxt.cmd.iso_zlp    = 1'b0;
      s_nxt.cmd.fifo_flush = 1'b1;
      s_nxt.cmd.csr_clear  = 1'b1;
    end
    s_nxt.irq = |{in_flags, cm_flags};
  end

  // Self-clearing software reset request
  assign swrst_nxt = wr_acc & (address == IDX_CTRL) & writedata[CTRL_BRST];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      swrst_r <= 1'b0;
    end else begin
      swrst_r <= swrst_nxt;
    end
  end

  always_ff @(posedge clock or posedge arst) begin
    if (arst) begin
      s_r        <= '0;
      s_r.wreq   <= 1'b1;
      s_r.iso    <= CTRL_RST[CTRL_ISO];
      s_r.inh    <= CTRL_RST[CTRL_INH];
      s_r.inen   <= INEN_RST;
      s_r.cmen   <= CMEN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign readdata           = s_r.rdata;
  assign waitrequest        = s_r.wreq;
  assign cmd                = s_r.cmd;
  assign irq                = s_r.irq;
  assign link_inhibit       = s_r.inh;
  assign resume_drive       = s_r.resume;
  assign suspend_state_flag = s_r.susp;
  assign function_addr_reg  = s_r.fn_addr;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (arst);

  sequence iso_held;
    s_r.iso && live && ev.iso_load && !ev.sof && !s_r.cmd.iso_ready
      && !brst_rise;
  endsequence
  sequence iso_quiet;
    !ev.sof && !ev.iso_load && !brst_rise;
  endsequence
  sequence early_token;
    live && ev.iso_token && !ev.sof && !brst_rise;
  endsequence

  a_flags_ro: assert property (
    wr_acc && address == IDX_INFLG && !brst_rise
    |=> (in_flags & $past(in_flags)) == $past(in_flags))
    else $error("Write disturbed IN flags");
  a_enable_sep: assert property (
    wr_acc && address == IDX_INEN && !brst_rise
    |=> s_r.inen == $past(writedata[1:0])
        && in_flags == ($past(in_flags) | $past(in_set)))
    else $error("Enable write wrong");
  a_irq_any: assert property (
    $rose(|{in_flags, cm_flags}) |=> irq ##1 1'b1)
    else $error("Interrupt not raised");
  a_read_clears: assert property (
    rd_acc && address == IDX_INFLG && in_set == '0
    |=> (in_flags & $past(s_r.clrin)) == '0)
    else $error("Read did not clear flags");
  a_bus_reset: assert property (
    brst_rise |=> function_addr_reg == 7'h00 && cmd.fifo_flush
      && cmd.csr_clear && cm_flags[CM_RST] && s_r.inen == 2'h3)
    else $error("Bus reset effects missing");
  a_iso_hold: assert property (
    iso_held ##1 iso_quiet ##1 early_token |=> cmd.iso_zlp && !cmd.iso_ready)
    else $error("ISO packet not held");
  a_inh_sticky: assert property (
    !link_inhibit |=> !link_inhibit)
    else $error("Inhibit set by software");
  a_frame_cap: assert property (
    live && ev.sof |=> s_r.frame == $past(ev.frame) ##1 1'b1)
    else $error("Frame number not captured");
endmodule
`default_nettype wire

// >>> core/ufp_flag_bank.sv
`default_nettype none
module ufp_flag_bank
  import ufp_pkg::*;
#(
  parameter int unsigned W = 2
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] f;
  } ufp_fb_st_t;

  ufp_fb_st_t   s_r;
  ufp_fb_st_t   s_nxt;
  logic [W-1:0] f_nxt;

  // ==========================================================
  // Sticky flags, set beats clear
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign f_nxt[i] = set[i] | (s_r.f[i] & ~clr[i]);
  end

  always_comb begin
    s_nxt   = s_r;
    s_nxt.f = f_nxt;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flags = s_r.f;

  a_set_wins: assert property (@(posedge clock) disable iff (rst)
    (|set) |=> ((flags & $past(set)) == $past(set)))
    else $error("Flag set lost against clear");
endmodule
`default_nettype wire

// >>> include/ufp_pkg.sv
`default_nettype none
package ufp_pkg;
  // ==========================================================
  // Register indexes (byte address is four times the index)
  localparam int unsigned AW          = 4;
  localparam logic [3:0]  IDX_FNADDR  = 4'h0;
  localparam logic [3:0]  IDX_CTRL    = 4'h1;
  localparam logic [3:0]  IDX_INFLG   = 4'h2;
  localparam logic [3:0]  IDX_CMFLG   = 4'h6;
  localparam logic [3:0]  IDX_INEN    = 4'h7;
  localparam logic [3:0]  IDX_CMEN    = 4'h8;
  localparam logic [3:0]  IDX_FRML    = 4'hc;
  localparam logic [3:0]  IDX_FRMH    = 4'hd;
  localparam logic [3:0]  IDX_INDEX   = 4'he;
  // ==========================================================
  // Control register fields
  localparam int unsigned CTRL_ISO    = 7;
  localparam int unsigned CTRL_INH    = 4;
  localparam int unsigned CTRL_BRST   = 3;
  localparam int unsigned CTRL_RES    = 2;
  localparam int unsigned CTRL_SUSP   = 1;
  localparam int unsigned CTRL_SUSDET = 0;
  // ==========================================================
  // Flag and enable fields
  localparam int unsigned IN_EP1      = 1;
  localparam int unsigned IN_CTL      = 0;
  localparam int unsigned CM_SOF      = 3;
  localparam int unsigned CM_RST      = 2;
  localparam int unsigned CM_RSU      = 1;
  localparam int unsigned CM_SUS      = 0;
  localparam int unsigned IN_W        = 2;
  localparam int unsigned CM_W        = 4;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  CTRL_RST    = 8'h10;
  localparam logic [1:0]  INEN_RST    = 2'h3;
  localparam logic [3:0]  CMEN_RST    = 4'h6;
  localparam logic [3:0]  CMEN_BUSRST = 4'he;
  localparam logic [6:0]  FNADDR_RST  = 7'h00;
  localparam logic [3:0]  INDEX_RST   = 4'h0;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        sof;
    logic [10:0] frame;
    logic        bus_reset;
    logic        suspend;
    logic        resume;
    logic        ctl_ep;
    logic        ep1_in;
    logic        iso_load;
    logic        iso_token;
  } ufp_link_ev_t;
  typedef struct packed {
    logic iso_ready;
    logic iso_zlp;
    logic fifo_flush;
    logic csr_clear;
  } ufp_link_cmd_t;
endpackage
`default_nettype wire

// >>> tb/ufp_core_test.sv
`default_nettype none
module ufp_core_test
  import ufp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clock, rst, read, write, waitrequest, irq;
  logic          link_inhibit, resume_drive, suspend_state_flag;
  logic [AW-1:0] address;
  logic [7:0]    writedata, readdata;
  logic [6:0]    function_addr_reg;
  ufp_link_ev_t  ev;
  ufp_link_cmd_t cmd;
  int            bad_count  = 0;
  int            n_compared = 0;
  logic          cpu_ext_int_enable = 1'b0;
  // Resume hold scaled down from the 10 to 15 ms window to keep runs short
  localparam int RESUME_HOLD = 1000;

  ufp_core uut (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .ev(ev), .cmd(cmd), .irq(irq),
    .link_inhibit(link_inhibit), .resume_drive(resume_drive),
    .suspend_state_flag(suspend_state_flag),
    .function_addr_reg(function_addr_reg));
  ufp_host_model host (.clock(clock), .ev(ev), .cmd(cmd));

  // ==========================================================
  // Shared tasks
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr_en, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address   <= a;
    write     <= wr_en;
    read      <= !wr_en;
    writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic settle;
    repeat (2) @(posedge clock);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdc(IDX_CTRL, CTRL_RST);
    rdc(IDX_INFLG, 8'h00);
    rdc(IDX_FRML, 8'h00);
    rdc(IDX_FRMH, 8'h00);
    rdc(4'h3, 8'h00);
    chk({7'h0, link_inhibit}, 8'h01);
  endtask
  task automatic t_inhibit;
    ufp_link_ev_t e;
    e = '0;
    e.ctl_ep = 1'b1;
    host.fire(e, 1);
    settle();
    chk({7'h0, irq}, 8'h00);
    rdc(IDX_INFLG, 8'h00);
    wr(IDX_CTRL, 8'h00);
    settle();
    chk({7'h0, link_inhibit}, 8'h00);
    wr(IDX_CTRL, 8'h10);
    rdc(IDX_CTRL, 8'h00);
  endtask
  task automatic t_flags;
    ufp_link_ev_t e;
    e = '0;
    e.ctl_ep = 1'b1;
    e.ep1_in = 1'b1;
    host.fire(e, 1);
    settle();
    chk({7'h0, irq}, 8'h01);
    wr(IDX_INFLG, 8'hff);
    chk({7'h0, irq}, 8'h01);
    rdc(IDX_INFLG, 8'h03);
    rdc(IDX_INFLG, 8'h00);
    settle();
    chk({7'h0, irq}, 8'h00);
    wr(IDX_INEN, 8'h00);
    host.fire(e, 1);
    settle();
    chk({7'h0, irq}, 8'h00);
    rdc(IDX_INEN, 8'h00);
    wr(IDX_INEN, 8'h03);
  endtask
  task automatic t_frame;
    ufp_link_ev_t e;
    e = '0;
    e.sof = 1'b1;
    e.frame = 11'h5a3;
    host.fire(e, 1);
    rdc(IDX_FRML, 8'ha3);
    rdc(IDX_FRMH, 8'h05);
  endtask
  task automatic t_busrst;
    ufp_link_ev_t e;
    e = '0;
    e.ep1_in = 1'b1;
    wr(IDX_FNADDR, 8'h2a);
    wr(IDX_INDEX, 8'h05);
    host.fire(e, 1);
    wr(IDX_INEN, 8'h00);
    wr(IDX_CMEN, 8'h00);
    e = '0;
    e.bus_reset = 1'b1;
    host.fire(e, 3);
    settle();
    chk({1'b0, function_addr_reg}, 8'h00);
    chk(8'(host.flush_count), 8'h01);
    chk(8'(host.csr_count), 8'h01);
    rdc(IDX_INDEX, 8'h00);
    rdc(IDX_INFLG, 8'h00);
    rdc(IDX_INEN, 8'h03);
    rdc(IDX_CMEN, 8'h0e);
    rdc(IDX_CMFLG, 8'h04);
  endtask
  task automatic t_iso;
    ufp_link_ev_t e;
    wr(IDX_CTRL, 8'h80);
    e = '0;
    e.iso_load = 1'b1;
    host.fire(e, 1);
    e = '0;
    e.iso_token = 1'b1;
    host.fire(e, 1);
    settle();
    chk(8'(host.zlp_count), 8'h01);
    chk({7'h0, cmd.iso_ready}, 8'h00);
    e = '0;
    e.sof = 1'b1;
    e.frame = 11'h7c5;
    host.fire(e, 1);
    settle();
    chk({7'h0, cmd.iso_ready}, 8'h01);
  endtask
  task automatic t_resume;
    ufp_link_ev_t e;
    rdc(IDX_CMFLG, 8'h08);
    wr(IDX_CMEN, 8'h0f);
    wr(IDX_CTRL, 8'h01);
    e = '0;
    e.suspend = 1'b1;
    host.fire(e, 1);
    settle();
    chk({7'h0, suspend_state_flag}, 8'h01);
    chk({7'h0, irq}, 8'h01);
    chk({7'h0, irq & cpu_ext_int_enable}, 8'h00);
    cpu_ext_int_enable = 1'b1;
    chk({7'h0, irq & cpu_ext_int_enable}, 8'h01);
    wr(IDX_CTRL, 8'h05);
    settle();
    chk({7'h0, resume_drive}, 8'h01);
    chk({7'h0, suspend_state_flag}, 8'h01);
    repeat (RESUME_HOLD) @(posedge clock);
    wr(IDX_CTRL, 8'h01);
    settle();
    chk({7'h0, resume_drive}, 8'h00);
    chk({7'h0, suspend_state_flag}, 8'h00);
    rdc(IDX_CMFLG, 8'h01);
    host.fire(e, 1);
    e = '0;
    e.resume = 1'b1;
    host.fire(e, 1);
    settle();
    chk({7'h0, suspend_state_flag}, 8'h00);
    rdc(IDX_CMFLG, 8'h03);
  endtask
  task automatic t_soft;
    wr(IDX_CTRL, 8'h08);
    settle();
    chk({7'h0, link_inhibit}, 8'h01);
    rdc(IDX_CTRL, CTRL_RST);
    rdc(IDX_FRML, 8'h00);
    rdc(IDX_CMEN, 8'h06);
  endtask

  // ==========================================================
  // Clock and main sequence
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_inhibit();
    t_flags();
    t_frame();
    t_busrst();
    t_iso();
    t_resume();
    t_soft();
    summarize();
  end
endmodule
`default_nettype wire

// >>> tb/ufp_host_model.sv
`default_nettype none
// ==========================================================
// Host side: drives link events, counts answers
module ufp_host_model
  import ufp_pkg::*;
(
  input  wire logic          clock,
  output ufp_link_ev_t       ev,
  input  wire ufp_link_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  int zlp_count   = 0;
  int flush_count = 0;
  int csr_count   = 0;
  initial ev = '0;
  always @(posedge clock) begin
    if (cmd.iso_zlp === 1'b1) zlp_count++;
    if (cmd.csr_clear === 1'b1) csr_count++;
    if (cmd.fifo_flush === 1'b1) flush_count++;
  end
  // Frame lines carry junk outside start-of-frame
  task automatic fire(input ufp_link_ev_t e, input int n);
    ufp_link_ev_t idle;
    idle = '0;
    idle.frame = ~e.frame;
    @(posedge clock);
    ev <= e;
    repeat (n) @(posedge clock);
    ev <= idle;
  endtask
endmodule
`default_nettype wire
